// *** hdl/dual_pll_control_register_bank.sv ***
// Control register bank for the two-stage clock synthesizer
//
// Summary of operation
// - 0x17 bit 0 bypasses first stage, reset 0
// - 0x18 bit 1 bypasses second stage, reset 0
// - 0x18 bit 0 oscillator range, keep 0
// - 0x1C bit 7 tuning polarity, reset positive
// - 0x1C bit 6 forces midpoint, resets 1
// - 0x1C bits 4:0 first pump code, reset 15
// - 0x1D bit 5 enables phase offset, reset 0
// - 0x1D bits 4:0 offset code, reset 0
// - 0x1E bits 4:0 second pump code, reset 6
`include "pll_ctrl_regs.svh"
`default_nettype none

module dual_pll_control_register_bank (
	input wire logic sys_clk,
	input wire logic rst,
	input wire pll_ctrl_pkg::reg_req_t req,
	output var logic [7:0] rdata,
	output var pll_ctrl_pkg::pll_ctrl_t ctrl
);
	import pll_ctrl_pkg::*;

	// ********************************
	// Address decode
	// ********************************
	// A write needs strobe and select in the same cycle
	logic sel_first_bypass;
	logic sel_second_bypass;
	logic sel_loop;
	logic sel_offset;
	logic sel_second_pump;

	// Write strobes, one per register
	logic wr_first_bypass;
	logic wr_second_bypass;
	logic wr_loop;
	logic wr_offset;
	logic wr_second_pump;

	always_comb begin
		sel_first_bypass =
			(req.addr == `ADDR_FIRST_STAGE_BYPASS_CTRL);
		sel_second_bypass =
			(req.addr == `ADDR_SECOND_STAGE_BYPASS_CTRL);
		sel_loop =
			(req.addr == `ADDR_FIRST_STAGE_LOOP_CTRL);
		sel_offset =
			(req.addr == `ADDR_FIRST_STAGE_PHASE_OFFSET_CTRL);
		sel_second_pump =
			(req.addr == `ADDR_SECOND_STAGE_PUMP_CTRL);
		wr_first_bypass = req.wr_en && sel_first_bypass;
		wr_second_bypass = req.wr_en && sel_second_bypass;
		wr_loop = req.wr_en && sel_loop;
		wr_offset = req.wr_en && sel_offset;
		wr_second_pump = req.wr_en && sel_second_pump;
	end

	// ********************************
	// First stage bypass register
	// ********************************
	// Writes to other banks leave this field alone
	logic first_bypass_reg;
	logic first_bypass_next;

	always_comb begin
		first_bypass_next = first_bypass_reg;
		if (wr_first_bypass) begin
			first_bypass_next =
				req.wdata[`BIT_FIRST_STAGE_BYPASS];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			first_bypass_reg <= `RST_FIRST_STAGE_BYPASS;
		end else begin
			first_bypass_reg <= first_bypass_next;
		end
	end

	// ********************************
	// Second stage bypass and range register
	// ********************************
	logic second_bypass_reg;
	logic second_bypass_next;
	logic range_select_reg;
	logic range_select_next;

	// The range bit is stored as written; a 1 is software misuse
	always_comb begin
		second_bypass_next = second_bypass_reg;
		range_select_next = range_select_reg;
		if (wr_second_bypass) begin
			second_bypass_next =
				req.wdata[`BIT_SECOND_STAGE_BYPASS];
			range_select_next =
				req.wdata[`BIT_OSCILLATOR_RANGE_SELECT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			second_bypass_reg <= `RST_SECOND_STAGE_BYPASS;
			range_select_reg <=
				`RST_OSCILLATOR_RANGE_SELECT;
		end else begin
			second_bypass_reg <= second_bypass_next;
			range_select_reg <= range_select_next;
		end
	end

	// ********************************
	// First stage loop register
	// ********************************
	logic polarity_reg;
	logic polarity_next;
	logic midpoint_reg;
	logic midpoint_next;
	logic [4:0] first_pump_reg;
	logic [4:0] first_pump_next;

	// Force-midpoint resets high so the oscillator starts centred
	always_comb begin
		polarity_next = polarity_reg;
		midpoint_next = midpoint_reg;
		first_pump_next = first_pump_reg;
		if (wr_loop) begin
			polarity_next =
				req.wdata[`BIT_OSCILLATOR_TUNING_POLARITY];
			midpoint_next =
				req.wdata[`BIT_FORCE_MIDPOINT_VOLTAGE];
			first_pump_next =
				req.wdata[`CODE_MSB:`CODE_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			polarity_reg <=
				`RST_OSCILLATOR_TUNING_POLARITY;
			midpoint_reg <=
				`RST_FORCE_MIDPOINT_VOLTAGE;
			first_pump_reg <=
				`RST_FIRST_STAGE_PUMP_CODE;
		end else begin
			polarity_reg <= polarity_next;
			midpoint_reg <= midpoint_next;
			first_pump_reg <= first_pump_next;
		end
	end

	// ********************************
	// First stage phase offset register
	// ********************************
	logic shift_enable_reg;
	logic shift_enable_next;
	logic [4:0] shift_code_reg;
	logic [4:0] shift_code_next;

	// The code is kept even while the offset is disabled
	always_comb begin
		shift_enable_next = shift_enable_reg;
		shift_code_next = shift_code_reg;
		if (wr_offset) begin
			shift_enable_next =
				req.wdata[`BIT_PHASE_SHIFT_ENABLE];
			shift_code_next =
				req.wdata[`CODE_MSB:`CODE_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shift_enable_reg <= `RST_PHASE_SHIFT_ENABLE;
			shift_code_reg <=
				`RST_STATIC_PHASE_SHIFT_FIELD;
		end else begin
			shift_enable_reg <= shift_enable_next;
			shift_code_reg <= shift_code_next;
		end
	end

	// ********************************
	// Second stage pump register
	// ********************************
	logic [4:0] second_pump_reg;
	logic [4:0] second_pump_next;

	always_comb begin
		second_pump_next = second_pump_reg;
		if (wr_second_pump) begin
			second_pump_next =
				req.wdata[`CODE_MSB:`CODE_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			second_pump_reg <=
				`RST_SECOND_STAGE_PUMP_CODE;
		end else begin
			second_pump_reg <= second_pump_next;
		end
	end

	// ********************************
	// Read images
	// ********************************
	// Reserved bits are held at zero here, never stored
	logic [7:0] image_first_bypass;
	logic [7:0] image_second_bypass;
	logic [7:0] image_loop;
	logic [7:0] image_offset;
	logic [7:0] image_second_pump;

	always_comb begin
		image_first_bypass = `READ_ZERO;
		image_second_bypass = `READ_ZERO;
		image_loop = `READ_ZERO;
		image_offset = `READ_ZERO;
		image_second_pump = `READ_ZERO;

		image_first_bypass[`BIT_FIRST_STAGE_BYPASS] =
			first_bypass_reg;
		image_second_bypass[`BIT_SECOND_STAGE_BYPASS] =
			second_bypass_reg;
		image_second_bypass[`BIT_OSCILLATOR_RANGE_SELECT] =
			range_select_reg;
		image_loop[`BIT_OSCILLATOR_TUNING_POLARITY] =
			polarity_reg;
		image_loop[`BIT_FORCE_MIDPOINT_VOLTAGE] =
			midpoint_reg;
		image_loop[`CODE_MSB:`CODE_LSB] =
			first_pump_reg;
		image_offset[`BIT_PHASE_SHIFT_ENABLE] =
			shift_enable_reg;
		image_offset[`CODE_MSB:`CODE_LSB] =
			shift_code_reg;
		image_second_pump[`CODE_MSB:`CODE_LSB] =
			second_pump_reg;
	end

	// ********************************
	// Read data register
	// ********************************
	// One cycle of latency keeps the read path a clean flop;
	// a read in the cycle of a write still shows the old value
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	always_comb begin
		if (sel_first_bypass) begin
			rdata_next = image_first_bypass;
		end else if (sel_second_bypass) begin
			rdata_next = image_second_bypass;
		end else if (sel_loop) begin
			rdata_next = image_loop;
		end else if (sel_offset) begin
			rdata_next = image_offset;
		end else if (sel_second_pump) begin
			rdata_next = image_second_pump;
		end else begin
			// Other addresses belong to other banks
			rdata_next = `READ_ZERO;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_reg <= `READ_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	// Every field comes straight from its own flop
	always_comb begin
		ctrl.first_stage_bypass = first_bypass_reg;
		ctrl.second_stage_bypass = second_bypass_reg;
		ctrl.oscillator_range_select = range_select_reg;
		ctrl.oscillator_tuning_polarity = polarity_reg;
		ctrl.force_midpoint_voltage = midpoint_reg;
		ctrl.first_stage_pump_code = first_pump_reg;
		ctrl.phase_shift_enable = shift_enable_reg;
		ctrl.static_phase_shift_field = shift_code_reg;
		ctrl.second_stage_pump_code = second_pump_reg;
	end

	assign rdata = rdata_reg;

endmodule : dual_pll_control_register_bank
`default_nettype wire

// *** hdl/pll_ctrl_regs.svh ***
// Register offsets, field positions and reset values of the PLL control bank
`ifndef PLL_CTRL_REGS_SVH
`define PLL_CTRL_REGS_SVH

`define ADDR_FIRST_STAGE_BYPASS_CTRL 8'h17
`define ADDR_SECOND_STAGE_BYPASS_CTRL 8'h18
`define ADDR_FIRST_STAGE_LOOP_CTRL 8'h1C
`define ADDR_FIRST_STAGE_PHASE_OFFSET_CTRL 8'h1D
`define ADDR_SECOND_STAGE_PUMP_CTRL 8'h1E

`define BIT_FIRST_STAGE_BYPASS 0
`define BIT_OSCILLATOR_RANGE_SELECT 0
`define BIT_SECOND_STAGE_BYPASS 1
`define BIT_OSCILLATOR_TUNING_POLARITY 7
`define BIT_FORCE_MIDPOINT_VOLTAGE 6
`define BIT_PHASE_SHIFT_ENABLE 5
`define CODE_MSB 4
`define CODE_LSB 0

`define RST_FIRST_STAGE_BYPASS 1'b0
`define RST_SECOND_STAGE_BYPASS 1'b0
`define RST_OSCILLATOR_RANGE_SELECT 1'b0
`define RST_OSCILLATOR_TUNING_POLARITY 1'b0
`define RST_FORCE_MIDPOINT_VOLTAGE 1'b1
`define RST_FIRST_STAGE_PUMP_CODE 5'h0F
`define RST_PHASE_SHIFT_ENABLE 1'b0
`define RST_STATIC_PHASE_SHIFT_FIELD 5'h00
`define RST_SECOND_STAGE_PUMP_CODE 5'h06

`define READ_ZERO 8'h00

`endif

// *** hdl/pll_ctrl_pkg.sv ***
// Types shared by the PLL control register bank
`default_nettype none
package pll_ctrl_pkg;

	// Register access request from the serial interface
	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Settings handed to the analog loops
	typedef struct packed {
		logic first_stage_bypass;
		logic second_stage_bypass;
		logic oscillator_range_select;
		logic oscillator_tuning_polarity;
		logic force_midpoint_voltage;
		logic [4:0] first_stage_pump_code;
		logic phase_shift_enable;
		logic [4:0] static_phase_shift_field;
		logic [4:0] second_stage_pump_code;
	} pll_ctrl_t;

endpackage : pll_ctrl_pkg
`default_nettype wire

// *** tb/pll_bank_sva.sv ***
// Assertions for the PLL control register bank
`default_nettype none
module pll_bank_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire pll_ctrl_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire pll_ctrl_pkg::pll_ctrl_t ctrl
);
	timeunit 1ns;
	timeprecision 1ns;
	import pll_ctrl_pkg::*;
	wire w = req.wr_en;
	wire [7:0] a = req.addr;
	wire [7:0] d = req.wdata;
	wire m = a inside {8'h17, 8'h18, 8'h1C, 8'h1D, 8'h1E};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ****
	// Writes reach ctrl one cycle later, reads lag a cycle
	// ****
	byp_a: assert property (w && a == 8'h17 |=>
		ctrl[20] == $past(d[0])) else $error("byp");
	src_a: assert property (w && a == 8'h18 |=>
		ctrl[19:18] == $past(d[1:0])) else $error("src");
	loop_a: assert property (w && a == 8'h1C |=>
		ctrl[17:11] == $past({d[7:6], d[4:0]})) else $error("loop");
	ofs_a: assert property (w && a == 8'h1D |=>
		ctrl[10:5] == $past(d[5:0])) else $error("ofs");
	cpf_a: assert property (w && a == 8'h1E |=>
		ctrl[4:0] == $past(d[4:0])) else $error("cpf");
	hold_a: assert property (!(w && m) |=> $stable(ctrl))
		else $error("hold");
	rd_a: assert property (a == 8'h1D |=>
		rdata == {2'h0, $past(ctrl[10:5])}) else $error("rd");
	unm_a: assert property (!m |=> rdata == 8'h00) else $error("unm");
	cover property (w && a == 8'h1C);
	cover property (w && !m);
	cover property (w ##1 a == 8'h1C);
endmodule : pll_bank_sva
bind dual_pll_control_register_bank pll_bank_sva chk (.sys_clk, .rst, .req,
	.rdata, .ctrl);
`default_nettype wire

// *** tb/dual_pll_control_register_bank_test.sv ***
// Testbench for the PLL control register bank
`default_nettype none
module dual_pll_control_register_bank_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pll_ctrl_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	reg_req_t req = '0;
	logic [7:0] rdata;
	pll_ctrl_t ctrl;
	int err_total = 0;
	int compares = 0;
	logic [7:0] adr [5] = '{8'h17, 8'h18, 8'h1C, 8'h1D, 8'h1E};
	logic [7:0] ones [5] = '{8'h01, 8'h02, 8'hDF, 8'h3F, 8'h1F};
	dual_pll_control_register_bank dut (.sys_clk, .rst, .req, .rdata, .ctrl);
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		#1000000 err_total++;
		stop_test();
	end
	task chk(input logic [20:0] g, input logic [20:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) req <= '{1'b1, a, d};
		@(posedge sys_clk) req.wr_en <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk) req <= '{1'b0, a, 8'h00};
		@(posedge sys_clk) #1 chk(21'(rdata), 21'(e));
	endtask : rd
	// ****
	// Scenarios
	// ****
	task t_reset;
		#1 chk(ctrl, {4'h0, 1'b1, 5'h0F, 1'b0, 5'h00, 5'h06});
		rd(8'h1C, 8'h4F);
	endtask : t_reset
	// Range bit stays 0: software may never set it
	task t_regs;
		for (int i = 0; i < 5; i++) wr(adr[i], i == 1 ? 8'hFE : 8'hFF);
		wr(8'h20, 8'h00);
		#1 chk(ctrl, {4'hD, 1'b1, 5'h1F, 1'b1, 5'h1F, 5'h1F});
		for (int i = 0; i < 5; i++) rd(adr[i], ones[i]);
		rd(8'hFF, 8'h00);
		for (int i = 0; i < 5; i++) wr(adr[i], 8'h00);
		#1 chk(ctrl, 21'h0);
	endtask : t_regs
	task t_walk;
		@(posedge sys_clk) req <= '{1'b1, 8'h1C, 8'h85};
		@(posedge sys_clk) req.wr_en <= 1'b0;
		#1 chk(21'(rdata), 21'h0);
		@(posedge sys_clk) #1 chk(21'(rdata), 21'h85);
	endtask : t_walk
	// Mid-run reset restores every field
	task t_rerst;
		wr(8'h1D, 8'h25);
		#1 chk(21'(ctrl[10:5]), 21'h25);
		@(posedge sys_clk) rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1 chk(ctrl, {4'h0, 1'b1, 5'h0F, 1'b0, 5'h00, 5'h06});
		rd(8'h1D, 8'h00);
	endtask : t_rerst
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_walk();
		t_rerst();
		stop_test();
	end
	task stop_test;
		$display("errors %0d of %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
endmodule : dual_pll_control_register_bank_test
`default_nettype wire
